// [bench/tb_top.sv]
// self-checking bench for the trigger control block
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top
    import ttc_pkg::*;
();
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] probe_data = '0;
    logic [15:0] wave = 16'h5a3c;
    logic tie0 = 1'b0;
    logic lnk = 1'b0;
    logic [5:0] proc_addr;
    logic sdat, hbit, proc_wr, proc_rd, arm_word_match_n, trig_word_match_n;
    logic storage_write, post_trigger_enable, acquisition_done;
    logic [7:0] proc_rd_data, d;
    logic [15:0] a1, a0, t1, t0, storage_bus_bit;
    logic [15:0] pv [3] = '{16'h0005, 16'h0007, 16'h000d};
    logic [1:0] em [3] = '{2'b00, 2'b10, 2'b01};
    int n_fail = 0, n_checks = 0, n, cyc = 0;
    ttc_trigger_control DUT (.mclk(mclk), .sys_rst(sys_rst), .proc_addr(proc_addr),
        .serial_config_bit(sdat), .halt_set_bit(hbit), .proc_wr(proc_wr), .proc_rd(proc_rd),
        .proc_rd_data(proc_rd_data), .probe_data(probe_data), .waveform_sample_bit(wave),
        .ext_sample_clock(tie0), .state_link_in(lnk), .waveform_link_in(tie0),
        .external_link_in(tie0), .arm_bit_sel_one_n(a1), .arm_bit_sel_zero_n(a0),
        .trig_bit_sel_one_n(t1), .trig_bit_sel_zero_n(t0), .arm_word_match_n(arm_word_match_n),
        .trig_word_match_n(trig_word_match_n), .storage_bus_bit(storage_bus_bit),
        .storage_write(storage_write), .post_trigger_enable(post_trigger_enable),
        .acquisition_done(acquisition_done));
    ttc_host_model host (.mclk(mclk), .proc_addr(proc_addr), .serial_config_bit(sdat),
        .halt_set_bit(hbit), .proc_wr(proc_wr), .proc_rd(proc_rd), .proc_rd_data(proc_rd_data));
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // which: 0 storage write, 1 post-trigger enable, 2 done; n is lim when never seen
    task automatic wait_hi(input int which, input int lim, output int n);
        logic [2:0] w;
        for (n = 0; n < lim; n++) begin
            @(negedge mclk);
            w = {acquisition_done, post_trigger_enable, storage_write};
            if (w[which] === 1'b1) break;
        end
    endtask
    function automatic logic [159:0] cfg(input logic [15:0] av, ac, tv, tc, src,
        input logic [3:0] af, input logic [9:0] post);
        cfg = TTC_CFG_RST;
        cfg[F_ARM_VAL +: 16] = av;
        cfg[F_ARM_CARE +: 16] = ac;
        cfg[F_TRG_VAL +: 16] = tv;
        cfg[F_TRG_CARE +: 16] = tc;
        cfg[F_SRC_SEL +: 16] = src;
        cfg[F_ARM_FLT +: 4] = af;
        cfg[F_POST +: 10] = post;
    endfunction
    initial begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        host.load(cfg(16'h0001, 16'h0003, 16'h0004, 16'h000c, 16'h00ff, 4'h0, 10'h000));
        repeat (2) @(negedge mclk);
        `CHK({a1, a0}, {16'hfffe, 16'hfffd})
        `CHK({t1, t0}, {16'hfffb, 16'hfff7})
        // stay idle: a started sequencer would halt and freeze the storage bus
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk);
            probe_data <= pv[i];
            repeat (8) @(posedge mclk);
            wait_hi(0, 50, n);
            `CHK(storage_bus_bit, (pv[i] & 16'h00ff) | (wave & 16'hff00))
            `CHK({arm_word_match_n, trig_word_match_n}, em[i])
        end
        // clear the probes so no stale match arms the filter test early
        @(posedge mclk);
        probe_data <= 16'h0000;
        $display("test comparators done");
        host.load(cfg(16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 4'h0, 10'd10));
        host.wr(DEC_START, 1'b0, 1'b0);
        wait_hi(1, 100, n);
        wait_hi(2, 100, n);
        `CHK(n >= 9 && n <= 12, 1'b1)
        host.rd({DEC_BASE, DEC_STATUS}, d);
        `CHK({d, post_trigger_enable}, {8'h09, 1'b1})
        wait_hi(0, 20, n);
        `CHK(n, 20)
        host.rd(6'h13, d);
        `CHK(d, 8'h00)
        host.wr(DEC_RESET, 1'b0, 1'b0);
        repeat (2) @(negedge mclk);
        `CHK({post_trigger_enable, acquisition_done, a1}, {2'b00, 16'hffff})
        $display("test post count done");
        host.load(cfg(16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 4'h2, 10'd10));
        host.wr(DEC_START, 1'b0, 1'b0);
        @(posedge mclk);
        probe_data <= 16'h0001;
        @(posedge mclk);
        probe_data <= 16'h0000;
        wait_hi(1, 20, n);
        `CHK(n, 20)
        @(posedge mclk);
        probe_data <= 16'h0001;
        wait_hi(1, 60, n);
        `CHK(post_trigger_enable, 1'b1)
        @(posedge mclk);
        probe_data <= 16'h0000;
        $display("test filter done");
        // arm word all don't-care, but the state link input is required
        host.load(cfg(16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 4'h2, 10'd10)
                  | (160'h1 << F_ARM_LINK));
        host.wr(DEC_START, 1'b0, 1'b0);
        wait_hi(1, 20, n);
        `CHK(n, 20)
        host.wr(DEC_PROC_STROBE, 1'b0, 1'b1);
        repeat (3) @(negedge mclk);
        host.rd({DEC_BASE, DEC_STATUS}, d);
        `CHK({d, acquisition_done, post_trigger_enable}, {8'h09, 2'b10})
        @(posedge mclk);
        lnk <= 1'b1;
        host.wr(DEC_START, 1'b0, 1'b0);
        wait_hi(1, 20, n);
        `CHK(post_trigger_enable, 1'b1)
        $display("test halt bit done");
        finish_test();
    end
endmodule // tb_top

// [bench/ttc_checker_sva.sv]
// port-level assertions for the trigger control block
`timescale 1ns/1ps
module ttc_checker
    import ttc_pkg::*;
#(
    parameter int CHANNELS = TTC_CHANNELS
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] proc_addr,
    input wire logic halt_set_bit,
    input wire logic proc_wr,
    input wire logic proc_rd,
    input wire logic [7:0] proc_rd_data,
    input wire logic [CHANNELS-1:0] arm_bit_sel_one_n,
    input wire logic [CHANNELS-1:0] arm_bit_sel_zero_n,
    input wire logic [CHANNELS-1:0] trig_bit_sel_one_n,
    input wire logic [CHANNELS-1:0] trig_bit_sel_zero_n,
    input wire logic arm_word_match_n,
    input wire logic storage_write,
    input wire logic post_trigger_enable,
    input wire logic acquisition_done
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // config reset and start writes are the only clears of the sticky flags
    wire clr_wr = proc_wr && (proc_addr == 6'h2a || proc_addr == 6'h2c);
    wire arm_all_x = &arm_bit_sel_one_n && &arm_bit_sel_zero_n;
    rd_idle_a: assert property (
        !(proc_rd && proc_addr == 6'h2b) |=> proc_rd_data == 8'h00) else $error("stray read data");
    arm_pair_a: assert property (
        (~arm_bit_sel_one_n & ~arm_bit_sel_zero_n) == '0) else $error("arm select pair both low");
    trig_pair_a: assert property (
        (~trig_bit_sel_one_n & ~trig_bit_sel_zero_n) == '0) else $error("trig select pair both low");
    done_hold_a: assert property (
        acquisition_done && !clr_wr |=> acquisition_done) else $error("done flag dropped");
    halt_set_a: assert property (
        proc_wr && proc_addr == 6'h28 && halt_set_bit |-> ##[1:2] acquisition_done)
        else $error("halt bit write ignored");
    cfg_clear_a: assert property (
        proc_wr && proc_addr == 6'h2a |-> ##[1:2] !post_trigger_enable && !acquisition_done)
        else $error("config reset left flags set");
    post_trigger_enable_hold_a: assert property (
        post_trigger_enable && !clr_wr |=> post_trigger_enable) else $error("post_trigger_enable dropped");
    sample_stop_a: assert property (
        acquisition_done [*4] |-> !storage_write) else $error("sampling after halt");
    dc_match_a: assert property (
        storage_write && arm_all_x && $past(arm_all_x, 3) |-> !arm_word_match_n)
        else $error("don't-care word did not match");
    cover property ($rose(post_trigger_enable));
    cover property ($rose(acquisition_done));
    cover property ($past(proc_rd) && proc_rd_data != 8'h00);
endmodule // ttc_checker

bind ttc_trigger_control ttc_checker #(.CHANNELS(CHANNELS)) u_chk (
    .mclk(mclk), .sys_rst(sys_rst), .proc_addr(proc_addr), .halt_set_bit(halt_set_bit),
    .proc_wr(proc_wr), .proc_rd(proc_rd), .proc_rd_data(proc_rd_data),
    .arm_bit_sel_one_n(arm_bit_sel_one_n), .arm_bit_sel_zero_n(arm_bit_sel_zero_n),
    .trig_bit_sel_one_n(trig_bit_sel_one_n), .trig_bit_sel_zero_n(trig_bit_sel_zero_n),
    .arm_word_match_n(arm_word_match_n), .storage_write(storage_write),
    .post_trigger_enable(post_trigger_enable), .acquisition_done(acquisition_done));

// [bench/ttc_host_model.sv]
// processor-side model of the block's register port
`timescale 1ns/1ps
module ttc_host_model
    import ttc_pkg::*;
(
    input wire logic mclk,
    output logic [ADDR_W-1:0] proc_addr,
    output logic serial_config_bit,
    output logic halt_set_bit,
    output logic proc_wr,
    output logic proc_rd,
    input wire logic [7:0] proc_rd_data
);
    initial begin
        proc_addr = '0;
        serial_config_bit = 1'b0;
        halt_set_bit = 1'b0;
        proc_wr = 1'b0;
        proc_rd = 1'b0;
    end
    task automatic wr(input logic [2:0] code, input logic d0, input logic d1);
        @(posedge mclk);
        proc_wr <= 1'b1;
        proc_addr <= {DEC_BASE, code};
        serial_config_bit <= d0;
        halt_set_bit <= d1;
        @(posedge mclk);
        proc_wr <= 1'b0;
        // data bits released: flip them so a stale level is never mistaken for data
        serial_config_bit <= ~d0;
        halt_set_bit <= ~d1;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge mclk);
        proc_rd <= 1'b1;
        proc_addr <= a;
        @(posedge mclk);
        proc_rd <= 1'b0;
        @(negedge mclk);
        d = proc_rd_data;
    endtask
    // first bit shifted lands at chain bit 0
    task automatic load(input logic [TTC_CFG_W-1:0] c);
        wr(DEC_RESET, 1'b0, 1'b0);
        for (int i = 0; i < TTC_CFG_W; i++) wr(DEC_SHIFT_CLOCK, c[i], 1'b0);
    endtask
endmodule // ttc_host_model

// [inc/ttc_pkg.sv]
// constants, configuration chain layout and state encoding for the trigger control block
package ttc_pkg;
    // channel count: two memory boards of eight channels
    localparam int TTC_BOARDS = 2;
    localparam int TTC_CH_PER_BOARD = 8;
    localparam int TTC_CHANNELS = TTC_BOARDS * TTC_CH_PER_BOARD;

    // configuration chain: ten shift registers
    localparam int TTC_SR_COUNT = 10;
    localparam int TTC_SR_WIDTH = 16;
    localparam int TTC_CFG_W = TTC_SR_COUNT * TTC_SR_WIDTH;
    localparam logic [TTC_CFG_W-1:0] TTC_CFG_RST = '0;

    // field positions in the chain
    localparam int F_ARM_VAL = 0;
    localparam int F_ARM_CARE = 16;
    localparam int F_TRG_VAL = 32;
    localparam int F_TRG_CARE = 48;
    localparam int F_GLITCH = 64;
    localparam int F_SRC_SEL = 80;
    localparam int F_ARM_FLT = 96;
    localparam int F_TRG_FLT = 100;
    localparam int F_ARM_LINK = 104;
    localparam int F_TRG_LINK = 107;
    localparam int F_DLY_MODE = 110;
    localparam int F_DLY_CNT = 112;
    localparam int F_DLY_ARMS = 126;
    localparam int F_RATE = 127;
    localparam int F_DIV = 130;
    localparam int F_EXT_EDGE = 132;
    localparam int F_POST = 134;
    localparam int FLT_W = 4;
    localparam int LINK_W = 3;
    localparam int DLY_W = 14;
    localparam int RATE_W = 3;
    localparam int DIV_W = 2;
    localparam int POST_W = 10;

    // post-trigger counter terminal value
    localparam logic [POST_W-1:0] TTC_POST_TERMINAL = 10'h3e8;

    // processor port decode: six address bits, one-of-eight on the low three
    localparam int ADDR_W = 6;
    localparam logic [2:0] DEC_BASE = 3'h5;
    localparam logic [2:0] DEC_PROC_STROBE = 3'h0;
    localparam logic [2:0] DEC_SHIFT_CLOCK = 3'h1;
    localparam logic [2:0] DEC_RESET = 3'h2;
    localparam logic [2:0] DEC_STATUS = 3'h3;
    localparam logic [2:0] DEC_START = 3'h4;

    // clock figures
    localparam int MCLK_MHZ = 125;
    localparam int OSC_MHZ = 200;
    localparam int EXT_MAX_MHZ = 75;
    localparam int INT_MIN_PERIOD_NS = 5;
    localparam int INT_MAX_PERIOD_MS = 50;
    localparam int PRESCALE_W = 20;
    localparam logic [PRESCALE_W-1:0] FIRST_STAGE_DIV = 20'h00002;
    localparam int DECADE_STAGES = 4;

    // external clock edge select
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;

    typedef enum logic [2:0] {
        TTC_IDLE = 3'b000,
        TTC_ARM_WAIT = 3'b001,
        TTC_DELAY = 3'b010,
        TTC_TRIG_WAIT = 3'b011,
        TTC_POST = 3'b100,
        TTC_HALT = 3'b101
    } ttc_state_e;
endpackage

// [src/ttc_trigger_control.sv]
// trigger, filter, sequencer and sample clock control for the timing analyzer
`timescale 1ns/1ps
module ttc_trigger_control
    import ttc_pkg::*;
#(
    parameter int CHANNELS = TTC_CHANNELS
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] proc_addr,
    input wire logic serial_config_bit,
    input wire logic halt_set_bit,
    input wire logic proc_wr,
    input wire logic proc_rd,
    output logic [7:0] proc_rd_data,
    input wire logic [CHANNELS-1:0] probe_data,
    input wire logic [CHANNELS-1:0] waveform_sample_bit,
    input wire logic ext_sample_clock,
    input wire logic state_link_in,
    input wire logic waveform_link_in,
    input wire logic external_link_in,
    output logic [CHANNELS-1:0] arm_bit_sel_one_n,
    output logic [CHANNELS-1:0] arm_bit_sel_zero_n,
    output logic [CHANNELS-1:0] trig_bit_sel_one_n,
    output logic [CHANNELS-1:0] trig_bit_sel_zero_n,
    output logic arm_word_match_n,
    output logic trig_word_match_n,
    output logic [CHANNELS-1:0] storage_bus_bit,
    output logic storage_write,
    output logic post_trigger_enable,
    output logic acquisition_done
);

    // per-bit comparator: match when the selected level agrees or bit is don't-care
    function automatic logic bit_match(input logic q, input logic sel_one_n,
                                       input logic sel_zero_n);
        bit_match = (q | sel_one_n) & (~q | sel_zero_n);
    endfunction

    // internal sample period in mclk cycles; decade 0 is the direct oscillator path
    function automatic logic [PRESCALE_W-1:0] sample_period(input logic [RATE_W-1:0] decade,
                                                            input logic [DIV_W-1:0] div);
        logic [PRESCALE_W-1:0] p;
        p = FIRST_STAGE_DIV;
        for (int i = 1; i <= DECADE_STAGES; i++) begin
            if (decade > RATE_W'(i)) begin
                p = PRESCALE_W'(p * 10);
            end
        end
        if (div == 2'h1) begin
            p = PRESCALE_W'(p * 2);
        end else if (div == 2'h2) begin
            p = PRESCALE_W'(p * 5);
        end
        sample_period = p;
    endfunction

    // filter step: reload while the condition is absent, count down while present
    function automatic logic [FLT_W:0] filter_step(input logic cond, input logic [FLT_W-1:0] len,
                                                   input logic [FLT_W-1:0] cnt);
        logic fire;
        logic [FLT_W-1:0] nxt;
        fire = 1'b0;
        nxt = len;
        if (cond) begin
            fire = (cnt <= 4'h1);
            nxt = (cnt == 4'h0) ? cnt : cnt - 4'h1;
        end
        filter_step = {fire, nxt};
    endfunction

    // ---------------- processor port decode ----------------
    wire logic block_hit = (proc_addr[ADDR_W-1:3] == DEC_BASE);
    wire logic dec_proc_strobe = proc_wr & block_hit & (proc_addr[2:0] == DEC_PROC_STROBE);
    wire logic dec_shift = proc_wr & block_hit & (proc_addr[2:0] == DEC_SHIFT_CLOCK);
    wire logic dec_reset = proc_wr & block_hit & (proc_addr[2:0] == DEC_RESET);
    wire logic dec_start = proc_wr & block_hit & (proc_addr[2:0] == DEC_START);
    wire logic status_read_enable = proc_rd & block_hit & (proc_addr[2:0] == DEC_STATUS);

    // ---------------- configuration chain ----------------
    logic [TTC_CFG_W-1:0] cfg_q;
    logic [TTC_CFG_W-1:0] cfg_d;
    // new bit enters at the top; after the full load the first bit sits at position 0
    assign cfg_d = dec_reset ? TTC_CFG_RST :
                   dec_shift ? {serial_config_bit, cfg_q[TTC_CFG_W-1:1]} : cfg_q;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cfg_q <= TTC_CFG_RST;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    wire logic [CHANNELS-1:0] arm_val = cfg_q[F_ARM_VAL +: CHANNELS];
    wire logic [CHANNELS-1:0] arm_care = cfg_q[F_ARM_CARE +: CHANNELS];
    wire logic [CHANNELS-1:0] trg_val = cfg_q[F_TRG_VAL +: CHANNELS];
    wire logic [CHANNELS-1:0] trg_care = cfg_q[F_TRG_CARE +: CHANNELS];
    wire logic [CHANNELS-1:0] glitch_mode = cfg_q[F_GLITCH +: CHANNELS];
    wire logic [CHANNELS-1:0] sample_source_select = cfg_q[F_SRC_SEL +: CHANNELS];
    wire logic [FLT_W-1:0] arm_flt_len = cfg_q[F_ARM_FLT +: FLT_W];
    wire logic [FLT_W-1:0] trg_flt_len = cfg_q[F_TRG_FLT +: FLT_W];
    wire logic [LINK_W-1:0] arm_link_req = cfg_q[F_ARM_LINK +: LINK_W];
    wire logic [LINK_W-1:0] trg_link_req = cfg_q[F_TRG_LINK +: LINK_W];
    wire logic [1:0] dly_mode = cfg_q[F_DLY_MODE +: 2];
    wire logic [DLY_W-1:0] dly_value = cfg_q[F_DLY_CNT +: DLY_W];
    wire logic dly_by_arms = cfg_q[F_DLY_ARMS];
    wire logic [RATE_W-1:0] rate_sel = cfg_q[F_RATE +: RATE_W];
    wire logic [DIV_W-1:0] div_sel = cfg_q[F_DIV +: DIV_W];
    wire logic [1:0] ext_edge = cfg_q[F_EXT_EDGE +: 2];
    wire logic [POST_W-1:0] post_value = cfg_q[F_POST +: POST_W];

    // select pairs: value 1 pulls select-one low, value 0 pulls select-zero low
    wire logic [CHANNELS-1:0] arm_one_n_d = ~(arm_care & arm_val);
    wire logic [CHANNELS-1:0] arm_zero_n_d = ~(arm_care & ~arm_val);
    wire logic [CHANNELS-1:0] trg_one_n_d = ~(trg_care & trg_val);
    wire logic [CHANNELS-1:0] trg_zero_n_d = ~(trg_care & ~trg_val);

    // ---------------- input synchronisers ----------------
    logic [CHANNELS-1:0] probe_s1_q;
    logic [CHANNELS-1:0] probe_s2_q;
    logic [CHANNELS-1:0] wave_s1_q;
    logic [CHANNELS-1:0] wave_s2_q;
    logic [3:0] misc_s1_q;
    logic [3:0] misc_s2_q;
    logic ext_prev_q;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            probe_s1_q <= '0;
            probe_s2_q <= '0;
            wave_s1_q <= '0;
            wave_s2_q <= '0;
            misc_s1_q <= 4'h0;
            misc_s2_q <= 4'h0;
            ext_prev_q <= 1'b0;
        end else begin
            probe_s1_q <= probe_data;
            probe_s2_q <= probe_s1_q;
            wave_s1_q <= waveform_sample_bit;
            wave_s2_q <= wave_s1_q;
            misc_s1_q <= {ext_sample_clock, external_link_in, waveform_link_in, state_link_in};
            misc_s2_q <= misc_s1_q;
            ext_prev_q <= misc_s2_q[3];
        end
    end

    wire logic [LINK_W-1:0] link_in = misc_s2_q[2:0];
    wire logic ext_clk_s = misc_s2_q[3];

    // ---------------- sample clock selection ----------------
    logic [PRESCALE_W-1:0] div_cnt_q;
    logic [PRESCALE_W-1:0] div_cnt_d;
    ttc_state_e state_q;
    ttc_state_e state_d;

    wire logic halted = (state_q == TTC_HALT);
    wire logic [PRESCALE_W-1:0] int_period = sample_period(rate_sel, div_sel);
    // rate code zero takes every mclk cycle with no divider in the path
    wire logic int_tick = (rate_sel == '0) ? 1'b1 : (div_cnt_q == '0);
    assign div_cnt_d = (rate_sel == '0 || div_cnt_q == '0) ?
                       int_period - PRESCALE_W'(1) : div_cnt_q - PRESCALE_W'(1);
    // external edges are seen at mclk resolution, so rates near half mclk may be missed
    wire logic ext_rise = ext_clk_s & ~ext_prev_q;
    wire logic ext_fall = ~ext_clk_s & ext_prev_q;
    wire logic use_ext = (ext_edge != 2'h0);
    wire logic ext_tick = (ext_edge[0] & ext_rise) | (ext_edge[1] & ext_fall);
    wire logic sample_tick = ~halted & (use_ext ? ext_tick : int_tick);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            div_cnt_q <= '0;
        end else begin
            div_cnt_q <= div_cnt_d;
        end
    end

    // ---------------- data capture and glitch catch ----------------
    logic [CHANNELS-1:0] sample_q;
    logic [CHANNELS-1:0] last_lvl_q;
    logic [CHANNELS-1:0] pulse_seen_q;
    logic [CHANNELS-1:0] sample_d;
    logic [CHANNELS-1:0] pulse_seen_d;

    // a change of level since the last sample is held so a short pulse still shows
    assign pulse_seen_d = sample_tick ? '0 :
                          pulse_seen_q | (probe_s2_q ^ last_lvl_q);
    assign sample_d = sample_tick ?
                      (probe_s2_q | (glitch_mode & (pulse_seen_q | (probe_s2_q ^ last_lvl_q))))
                      : sample_q;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sample_q <= '0;
            last_lvl_q <= '0;
            pulse_seen_q <= '0;
        end else begin
            sample_q <= sample_d;
            last_lvl_q <= probe_s2_q;
            pulse_seen_q <= pulse_seen_d;
        end
    end

    // ---------------- word comparators ----------------
    logic [CHANNELS-1:0] arm_bit_ok;
    logic [CHANNELS-1:0] trg_bit_ok;

    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            arm_bit_ok[c] = bit_match(sample_q[c], arm_one_n_d[c], arm_zero_n_d[c]);
            trg_bit_ok[c] = bit_match(sample_q[c], trg_one_n_d[c], trg_zero_n_d[c]);
        end
    end

    wire logic arm_word_hit = &arm_bit_ok;
    wire logic trg_word_hit = &trg_bit_ok;

    // ---------------- link stage ----------------
    // each requested link input must also be active; unrequested ones are ignored
    wire logic arm_cond = arm_word_hit & (&(link_in | ~arm_link_req));
    wire logic trg_cond = trg_word_hit & (&(link_in | ~trg_link_req));

    // ---------------- filters ----------------
    logic [FLT_W-1:0] arm_fcnt_q;
    logic [FLT_W-1:0] trg_fcnt_q;
    logic arm_filt_q;
    logic trg_filt_q;
    wire logic [FLT_W:0] arm_step = filter_step(arm_cond, arm_flt_len, arm_fcnt_q);
    wire logic [FLT_W:0] trg_step = filter_step(trg_cond, trg_flt_len, trg_fcnt_q);

    // filters advance only on sample ticks, so a length counts sample periods
    always_ff @(posedge mclk) begin
        if (sys_rst || dec_start) begin
            arm_fcnt_q <= '0;
            trg_fcnt_q <= '0;
            arm_filt_q <= 1'b0;
            trg_filt_q <= 1'b0;
        end else if (sample_tick) begin
            arm_fcnt_q <= arm_step[FLT_W-1:0];
            trg_fcnt_q <= trg_step[FLT_W-1:0];
            arm_filt_q <= arm_step[FLT_W];
            trg_filt_q <= trg_step[FLT_W];
        end
    end

    // ---------------- delay and post counters, sequencer ----------------
    logic [DLY_W-1:0] dly_cnt_q;
    logic [DLY_W-1:0] dly_cnt_d;
    logic [POST_W-1:0] post_cnt_q;
    logic [POST_W-1:0] post_cnt_d;
    logic arm_prev_q;
    logic post_trigger_enable_q;
    logic done_q;

    // by-arms mode steps once per arm that goes true and then false
    wire logic arm_gone = arm_prev_q & ~arm_filt_q;
    wire logic dly_step = dly_by_arms ? (sample_tick & arm_gone) : sample_tick;
    wire logic dly_zero = (dly_cnt_q == '0);
    wire logic allow_before = dly_mode[0] | (dly_mode == 2'h0);
    wire logic allow_after = dly_mode[1] | (dly_mode == 2'h0);
    wire logic trig_take = sample_tick & trg_filt_q &
                           (((state_q == TTC_DELAY) & ~dly_zero & allow_before) |
                            ((state_q == TTC_TRIG_WAIT) & allow_after));
    wire logic post_end = (state_q == TTC_POST) & (post_cnt_q == TTC_POST_TERMINAL);

    always_comb begin
        state_d = state_q;
        dly_cnt_d = dly_cnt_q;
        post_cnt_d = post_cnt_q;
        unique case (state_q)
            TTC_IDLE: begin
            end
            TTC_ARM_WAIT: begin
                dly_cnt_d = dly_value;
                if (sample_tick && arm_filt_q) begin
                    state_d = TTC_DELAY;
                end
            end
            TTC_DELAY: begin
                if (trig_take) begin
                    state_d = TTC_POST;
                end else if (dly_zero) begin
                    state_d = TTC_TRIG_WAIT;
                end else if (dly_step) begin
                    dly_cnt_d = dly_cnt_q - DLY_W'(1);
                end
            end
            TTC_TRIG_WAIT: begin
                if (trig_take) begin
                    state_d = TTC_POST;
                end
            end
            TTC_POST: begin
                if (post_end) begin
                    state_d = TTC_HALT;
                end else if (sample_tick) begin
                    post_cnt_d = post_cnt_q + POST_W'(1);
                end
            end
            TTC_HALT: begin
            end
            default: begin
                state_d = TTC_IDLE;
            end
        endcase
        if (trig_take) begin
            post_cnt_d = TTC_POST_TERMINAL - post_value;
        end
        if (dec_start) begin
            state_d = TTC_ARM_WAIT;
        end
        if (dec_reset) begin
            state_d = TTC_IDLE;
        end
        // a direct halt from the processor overrides every other move
        if (dec_proc_strobe && halt_set_bit) begin
            state_d = TTC_HALT;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q <= TTC_IDLE;
            dly_cnt_q <= '0;
            post_cnt_q <= '0;
            arm_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            dly_cnt_q <= dly_cnt_d;
            post_cnt_q <= post_cnt_d;
            arm_prev_q <= sample_tick ? arm_filt_q : arm_prev_q;
        end
    end

    // enable and done flags clear only on start or reset, set wins over clear
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            post_trigger_enable_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            post_trigger_enable_q <= trig_take | (post_trigger_enable_q & ~dec_start & ~dec_reset);
            done_q <= (state_d == TTC_HALT) | (done_q & ~dec_start & ~dec_reset);
        end
    end

    // ---------------- storage bus and outputs ----------------
    // stored data is taken before the filters, so filter settings never alter it
    wire logic [CHANNELS-1:0] bus_d = (sample_source_select & sample_q) |
                                      (~sample_source_select & wave_s2_q);
    wire logic [7:0] status_word = {4'h0, halted, state_q == TTC_TRIG_WAIT,
                                    state_q == TTC_DELAY,
                                    state_q != TTC_IDLE && state_q != TTC_ARM_WAIT};
    logic tick_d1_q;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            arm_bit_sel_one_n <= '1;
            arm_bit_sel_zero_n <= '1;
            trig_bit_sel_one_n <= '1;
            trig_bit_sel_zero_n <= '1;
            arm_word_match_n <= 1'b1;
            trig_word_match_n <= 1'b1;
            storage_bus_bit <= '0;
            storage_write <= 1'b0;
            tick_d1_q <= 1'b0;
            proc_rd_data <= 8'h00;
        end else begin
            arm_bit_sel_one_n <= arm_one_n_d;
            arm_bit_sel_zero_n <= arm_zero_n_d;
            trig_bit_sel_one_n <= trg_one_n_d;
            trig_bit_sel_zero_n <= trg_zero_n_d;
            arm_word_match_n <= ~arm_word_hit;
            trig_word_match_n <= ~trg_word_hit;
            tick_d1_q <= sample_tick;
            storage_write <= tick_d1_q;
            storage_bus_bit <= tick_d1_q ? bus_d : storage_bus_bit;
            proc_rd_data <= status_read_enable ? status_word : 8'h00;
        end
    end

    assign post_trigger_enable = post_trigger_enable_q;
    assign acquisition_done = done_q;

endmodule // ttc_trigger_control
